// File: atctb_regs.vh
/*
  Register offsets, field positions, reset values and channel filter count of the
  advanced timer clock-source and timebase core.
  Assumes inclusion by bare name from the timer design files.
*/
`ifndef ATCTB_REGS_VH
`define ATCTB_REGS_VH

// Register byte offsets on the AHB-Lite slave
`define ATCTB_CTRL_OFS 12'h000
`define ATCTB_SMC_OFS 12'h004
`define ATCTB_STS_OFS 12'h008
`define ATCTB_CNT_OFS 12'h00C
`define ATCTB_DIV_OFS 12'h010
`define ATCTB_RLD_OFS 12'h014
`define ATCTB_REP_OFS 12'h018
`define ATCTB_EGR_OFS 12'h01C

// Control register fields
`define ATCTB_CTRL_EN 0
`define ATCTB_CTRL_UDIS 1
`define ATCTB_CTRL_MODE_LO 2
`define ATCTB_CTRL_MODE_HI 3
`define ATCTB_CTRL_BUF 4

// Counting modes
`define ATCTB_MODE_UP 2'h0
`define ATCTB_MODE_DOWN 2'h1
`define ATCTB_MODE_CENTER 2'h2

// Slave mode control fields
`define ATCTB_SMC_SRC_LO 0
`define ATCTB_SMC_SRC_HI 2
`define ATCTB_SMC_POL 3
`define ATCTB_SMC_FLT_LO 4
`define ATCTB_SMC_FLT_HI 7
`define ATCTB_SMC_EDIV_LO 8
`define ATCTB_SMC_EDIV_HI 9
`define ATCTB_SMC_MSEL 10
`define ATCTB_SMC_PWMCH 11
`define ATCTB_SMC_RST 12

// Clock source codes
`define ATCTB_SRC_INT 3'h0
`define ATCTB_SRC_CH 3'h1
`define ATCTB_SRC_EDGE 3'h2
`define ATCTB_SRC_XTRG 3'h3
`define ATCTB_SRC_MTRG 3'h4

// Status flag positions
`define ATCTB_STS_UPD 0
`define ATCTB_STS_TRG 1
`define ATCTB_STS_CC 2
`define ATCTB_STS_BRK 3

// Reset values
`define ATCTB_CTRL_RST 32'h00000000
`define ATCTB_SMC_RST_VAL 32'h00000000
`define ATCTB_RLD_RST 16'hFFFF
`define ATCTB_DIV_RST 16'h0000
`define ATCTB_REP_RST 8'h00

// Number of channel input filters
`define ATCTB_FLT_TAPS 4

`endif

// File: atctb_filter.v
/*
  Polarity select and digital glitch filter for one timer input.
  Assumes the input is synchronous to hclk; filter length 0 passes through.
*/
`timescale 1ns/10ps
`include "atctb_regs.vh"

module atctb_filter (
  input wire hclk,
  input wire hresetn,
  input wire pin_in,
  input wire invert,
  input wire [3:0] flt_len,
  output wire flt_out
);

  reg [3:0] run_ff;
  reg out_ff;
  wire pol_in;

  assign pol_in = pin_in ^ invert;
  assign flt_out = (flt_len == 4'h0) ? pol_in : out_ff;

  // Output follows only after flt_len equal samples; spikes are dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ff <= 4'h0;
      out_ff <= 1'b0;
    end else if (pol_in == out_ff) begin
      run_ff <= 4'h0;
    end else if (run_ff >= flt_len - 4'h1) begin
      run_ff <= 4'h0;
      out_ff <= pol_in;
    end else begin
      run_ff <= run_ff + 4'h1;
    end
  end

endmodule

// File: atctb_core.v
/*
  Clock-source selection and 16-bit timebase of the advanced timer, with an
  AHB-Lite register slave. Channel, external trigger and internal trigger
  inputs are assumed synchronous to hclk; brake and capture events come in
  as one-cycle pulses from the channel logic outside.
*/
// The AHB-Lite slave port and the address map are this design's own decisions.
// Notes on behaviour
// - Four counter clock sources: internal, channel inputs, external trigger, internal trigger.
// - With slave mode off, prescaler clock is the internal timer clock.
// - Any channel input gets polarity and filtering before the slave controller.
// - Channel 1 both edges combine into a selectable both-edge pulse.
// - Pulse-width input measurement takes channel 1 or 2 only.
// - External trigger pin gets polarity, division, filtering, then trigger selector.
// - Internal trigger clock from another timer is not filtered.
// - Counter modes are up, down and center-aligned only.
// - Counter, reload value and clock divider are 16 bits.
// - Repetition count is 8 bits.
// - Four capture/compare channels plus brake; channel logic sits outside.
// - Complementary outputs and dead zone live outside; repetition counting here.
// - Update, trigger, capture/compare and brake events are raised.
// - Up mode counts from zero, wraps at reload with overflow.
// - Down mode counts from reload, reloads at zero with underflow.
// - Center mode overflows at reload minus one, underflows at one.
// - Update only on every N+1-th overflow or underflow, or on an EGR write.
`timescale 1ns/10ps
`include "atctb_regs.vh"

module atctb_core (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire [3:0] channel_in,
  input wire external_trigger_input,
  input wire [1:0] internal_trigger,
  input wire [3:0] capture_event,
  input wire brake_event,
  output wire [3:0] channel_filtered,
  output wire pwm_input_channel,
  output wire ch1_both_edge_pulse,
  output wire [15:0] count_value,
  output reg update_event,
  output reg trigger_event,
  output reg [3:0] cc_event,
  output reg brake_pulse
);

  reg [31:0] ctrl_ff;
  reg [31:0] smc_ff;
  reg [3:0] sts_ff;
  reg [15:0] cnt_ff;
  reg [15:0] div_ff;
  reg [15:0] div_sh_ff;
  reg [15:0] pcnt_ff;
  reg [15:0] rld_ff;
  reg [15:0] rld_sh_ff;
  reg [7:0] rep_ff;
  reg [7:0] rep_cnt_ff;
  reg dir_dn_ff;
  reg [3:0] chf_prev_ff;
  reg xtrg_raw_prev_ff;
  reg xtrg_prev_ff;
  reg [2:0] ediv_ff;
  reg mtrg_prev_ff;
  reg xtrg_div;
  reg wr_ff;
  reg [11:0] waddr_ff;
  reg [31:0] rdata_ff;

  wire [2:0] src;
  wire [1:0] mode;
  wire [3:0] flt_len;
  wire xtrg_pol;
  wire xtrg_raw_rise;
  wire xtrg_f;
  wire xtrg_edge;
  wire mtrg_sel;
  wire [3:0] ch_rise;
  wire prescaler_clock;
  wire counter_clock;
  wire ovf;
  wire unf;
  wire wrap;
  wire upd;
  wire sw_upd;
  wire buf_en;
  wire [1:0] ediv;
  wire ch_sel_tick;
  wire [15:0] cnt_nxt_up;
  reg [15:0] nxt_cnt;
  reg nxt_dir_dn;
  reg [3:0] nxt_sts;
  reg trg;

  assign src = smc_ff[`ATCTB_SMC_SRC_HI:`ATCTB_SMC_SRC_LO];
  assign mode = ctrl_ff[`ATCTB_CTRL_MODE_HI:`ATCTB_CTRL_MODE_LO];
  assign flt_len = smc_ff[`ATCTB_SMC_FLT_HI:`ATCTB_SMC_FLT_LO];
  assign ediv = smc_ff[`ATCTB_SMC_EDIV_HI:`ATCTB_SMC_EDIV_LO];
  assign buf_en = ctrl_ff[`ATCTB_CTRL_BUF];

  // One filter per channel and one for the external trigger
  genvar gi;
  generate
    for (gi = 0; gi < `ATCTB_FLT_TAPS; gi = gi + 1) begin : g_ch
      atctb_filter u_flt (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(channel_in[gi]),
        .invert(smc_ff[`ATCTB_SMC_POL]),
        .flt_len(flt_len),
        .flt_out(channel_filtered[gi])
      );
    end
  endgenerate

  // Trigger pin: polarity first, then edge division, then the filter
  assign xtrg_pol = external_trigger_input ^ smc_ff[`ATCTB_SMC_POL];
  assign xtrg_raw_rise = xtrg_pol & ~xtrg_raw_prev_ff;

  // Count raw rising edges; one counter bit gives divide by 2, 4 or 8
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ediv_ff <= 3'h0;
    end else if (xtrg_raw_rise) begin
      ediv_ff <= ediv_ff + 3'h1;
    end
  end

  // Divided level; changing the ratio may give one stray edge
  always @* begin
    case (ediv)
      2'h0: xtrg_div = xtrg_pol;
      2'h1: xtrg_div = ediv_ff[0];
      2'h2: xtrg_div = ediv_ff[1];
      default: xtrg_div = ediv_ff[2];
    endcase
  end

  atctb_filter u_xtrg (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(xtrg_div),
    .invert(1'b0),
    .flt_len(flt_len),
    .flt_out(xtrg_f)
  );

  // Edge detection on raw and filtered inputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chf_prev_ff <= 4'h0;
      xtrg_raw_prev_ff <= 1'b0;
      xtrg_prev_ff <= 1'b0;
      mtrg_prev_ff <= 1'b0;
    end else begin
      chf_prev_ff <= channel_filtered;
      xtrg_raw_prev_ff <= xtrg_pol;
      xtrg_prev_ff <= xtrg_f;
      mtrg_prev_ff <= mtrg_sel;
    end
  end

  assign ch_rise = channel_filtered & ~chf_prev_ff;
  assign ch1_both_edge_pulse = channel_filtered[0] ^ chf_prev_ff[0];
  assign pwm_input_channel = smc_ff[`ATCTB_SMC_PWMCH] ? channel_filtered[1]
                                                      : channel_filtered[0];
  assign ch_sel_tick = |(ch_rise & (4'h1 << smc_ff[`ATCTB_SMC_FLT_LO+1:`ATCTB_SMC_FLT_LO]));
  assign xtrg_edge = xtrg_f & ~xtrg_prev_ff;
  // Master trigger goes raw, no filter, so cascaded timers stay in step
  assign mtrg_sel = internal_trigger[smc_ff[`ATCTB_SMC_MSEL]];

  // Clock source select; internal clock when slave mode is off
  always @* begin
    case (src)
      `ATCTB_SRC_CH: trg = ch_sel_tick;
      `ATCTB_SRC_EDGE: trg = ch1_both_edge_pulse;
      `ATCTB_SRC_XTRG: trg = xtrg_edge;
      `ATCTB_SRC_MTRG: trg = mtrg_sel & ~mtrg_prev_ff;
      default: trg = 1'b1;
    endcase
  end
  assign prescaler_clock = trg & ctrl_ff[`ATCTB_CTRL_EN];

  // Prescaler: divide by value plus one
  assign counter_clock = prescaler_clock && (pcnt_ff == div_sh_ff);
  assign count_value = cnt_ff;
  assign cnt_nxt_up = cnt_ff + 16'h0001;

  // Overflow and underflow points per mode
  assign ovf = counter_clock && ((mode == `ATCTB_MODE_UP && cnt_ff == rld_sh_ff) ||
               (mode == `ATCTB_MODE_CENTER && !dir_dn_ff &&
                cnt_ff == rld_sh_ff - 16'h0001));
  assign unf = counter_clock && ((mode == `ATCTB_MODE_DOWN && cnt_ff == 16'h0000) ||
               (mode == `ATCTB_MODE_CENTER && dir_dn_ff && cnt_ff == 16'h0001));
  assign wrap = ovf | unf;
  assign upd = (wrap && rep_cnt_ff == 8'h00 && !ctrl_ff[`ATCTB_CTRL_UDIS]) || sw_upd;
  assign sw_upd = wr_ff && waddr_ff == `ATCTB_EGR_OFS && hwdata[0];

  // Next count and direction
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_dir_dn = dir_dn_ff;
    if (sw_upd) begin
      nxt_cnt = (mode == `ATCTB_MODE_DOWN) ? rld_ff : 16'h0000;
      nxt_dir_dn = 1'b0;
    end else if (counter_clock) begin
      case (mode)
        `ATCTB_MODE_UP: nxt_cnt = (cnt_ff == rld_sh_ff) ? 16'h0000 : cnt_nxt_up;
        `ATCTB_MODE_DOWN: nxt_cnt = (cnt_ff == 16'h0000) ? rld_sh_ff
                                                        : cnt_ff - 16'h0001;
        `ATCTB_MODE_CENTER: begin
          if (!dir_dn_ff) begin
            nxt_cnt = cnt_nxt_up;
            nxt_dir_dn = (cnt_nxt_up >= rld_sh_ff);
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
            nxt_dir_dn = (cnt_ff != 16'h0001);
          end
        end
        default: nxt_cnt = cnt_ff;
      endcase
    end
  end

  // Timebase state, shadows load on update
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 16'h0000;
      pcnt_ff <= 16'h0000;
      dir_dn_ff <= 1'b0;
      rep_cnt_ff <= `ATCTB_REP_RST;
      div_sh_ff <= `ATCTB_DIV_RST;
      rld_sh_ff <= `ATCTB_RLD_RST;
    end else begin
      cnt_ff <= (wr_ff && waddr_ff == `ATCTB_CNT_OFS) ? hwdata[15:0] : nxt_cnt;
      dir_dn_ff <= nxt_dir_dn;
      if (sw_upd) begin
        pcnt_ff <= 16'h0000;
      end else if (prescaler_clock) begin
        pcnt_ff <= (pcnt_ff == div_sh_ff) ? 16'h0000 : pcnt_ff + 16'h0001;
      end
      if (upd || (wrap && rep_cnt_ff == 8'h00)) begin
        rep_cnt_ff <= rep_ff;
      end else if (wrap) begin
        rep_cnt_ff <= rep_cnt_ff - 8'h01;
      end
      if (upd) begin
        div_sh_ff <= div_ff;
      end
      if (upd || !buf_en) begin
        rld_sh_ff <= rld_ff;
      end
    end
  end

  // Sticky status; hardware set wins over write-zero clear
  always @* begin
    nxt_sts = sts_ff;
    if (wr_ff && waddr_ff == `ATCTB_STS_OFS) begin
      nxt_sts = sts_ff & hwdata[3:0];
    end
    nxt_sts[`ATCTB_STS_UPD] = nxt_sts[`ATCTB_STS_UPD] | upd;
    nxt_sts[`ATCTB_STS_TRG] = nxt_sts[`ATCTB_STS_TRG] | (trg && src != `ATCTB_SRC_INT);
    nxt_sts[`ATCTB_STS_CC] = nxt_sts[`ATCTB_STS_CC] | (|capture_event);
    nxt_sts[`ATCTB_STS_BRK] = nxt_sts[`ATCTB_STS_BRK] | brake_event;
  end

  // Event pulses, registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_ff <= 4'h0;
      update_event <= 1'b0;
      trigger_event <= 1'b0;
      cc_event <= 4'h0;
      brake_pulse <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      update_event <= upd;
      trigger_event <= trg && src != `ATCTB_SRC_INT;
      cc_event <= capture_event;
      brake_pulse <= brake_event;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      waddr_ff <= 12'h000;
      rdata_ff <= 32'h00000000;
    end else begin
      wr_ff <= hsel && hready && htrans[1] && hwrite;
      waddr_ff <= haddr;
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr)
          `ATCTB_CTRL_OFS: rdata_ff <= ctrl_ff;
          `ATCTB_SMC_OFS: rdata_ff <= smc_ff;
          `ATCTB_STS_OFS: rdata_ff <= {28'h0000000, sts_ff};
          `ATCTB_CNT_OFS: rdata_ff <= {16'h0000, cnt_ff};
          `ATCTB_DIV_OFS: rdata_ff <= {16'h0000, div_ff};
          `ATCTB_RLD_OFS: rdata_ff <= {16'h0000, rld_ff};
          `ATCTB_REP_OFS: rdata_ff <= {24'h000000, rep_ff};
          default: rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // Writable configuration, taken in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `ATCTB_CTRL_RST;
      smc_ff <= `ATCTB_SMC_RST_VAL;
      div_ff <= `ATCTB_DIV_RST;
      rld_ff <= `ATCTB_RLD_RST;
      rep_ff <= `ATCTB_REP_RST;
    end else begin
      if (wr_ff) begin
        case (waddr_ff)
          `ATCTB_CTRL_OFS: ctrl_ff <= {27'h0000000, hwdata[4:0]};
          `ATCTB_SMC_OFS: smc_ff <= {19'h00000, hwdata[12:0]};
          `ATCTB_DIV_OFS: div_ff <= hwdata[15:0];
          `ATCTB_RLD_OFS: rld_ff <= hwdata[15:0];
          `ATCTB_REP_OFS: rep_ff <= hwdata[7:0];
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
      // Master start comes last so it wins over a clearing write
      if (smc_ff[`ATCTB_SMC_RST] && src == `ATCTB_SRC_MTRG && mtrg_sel) begin
        ctrl_ff[`ATCTB_CTRL_EN] <= 1'b1;
      end
    end
  end

endmodule

// File: atctb_core_checker.sv
/* Port checker for atctb_core.
   Assumes a single slave, so hready is the core's own hreadyout. */
`timescale 1ns/10ps
module atctb_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [3:0] capture_event,
  input wire brake_event,
  input wire [3:0] channel_filtered,
  input wire pwm_input_channel,
  input wire ch1_both_edge_pulse,
  input wire [15:0] count_value,
  input wire [3:0] cc_event,
  input wire brake_pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Accepted address phases
  wire rd_ph = hsel && hready && htrans[1] && !hwrite;
  wire wr_ph = hsel && hready && htrans[1] && hwrite;
  sequence s_brk_in;
    brake_event;
  endsequence
  sequence s_brk_out;
    ##1 brake_pulse;
  endsequence
  property p_cc;
    1'b1 |=> cc_event == $past(capture_event);
  endproperty
  a_cc: assert property (p_cc) else $error("capture pulse not passed on");
  property p_brk;
    s_brk_in |-> s_brk_out;
  endproperty
  a_brk: assert property (p_brk) else $error("brake pulse missing");
  property p_brk_src;
    brake_pulse |-> $past(brake_event);
  endproperty
  a_brk_src: assert property (p_brk_src) else $error("brake pulse without cause");
  property p_edge;
    ch1_both_edge_pulse == (channel_filtered[0] != $past(channel_filtered[0]));
  endproperty
  a_edge: assert property (p_edge) else $error("both-edge pulse wrong");
  property p_pwm;
    pwm_input_channel == channel_filtered[0] || pwm_input_channel == channel_filtered[1];
  endproperty
  a_pwm: assert property (p_pwm) else $error("pulse-width input not ch1 or ch2");
  property p_rdata;
    !$past(rd_ph) |-> $stable(hrdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without a read");
  // A write may load the counter; otherwise it steps by one or wraps
  property p_step;
    $changed(count_value) && !$past(wr_ph, 2) |-> count_value == $past(count_value) + 16'h1
      || count_value == $past(count_value) - 16'h1 || count_value == 16'h0
      || $past(count_value) == 16'h0;
  endproperty
  a_step: assert property (p_step) else $error("counter jumped");
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("slave stalled or erred");
endmodule

bind atctb_core atctb_chk i_atctb_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .capture_event(capture_event),
  .brake_event(brake_event), .channel_filtered(channel_filtered),
  .pwm_input_channel(pwm_input_channel), .ch1_both_edge_pulse(ch1_both_edge_pulse),
  .count_value(count_value), .cc_event(cc_event), .brake_pulse(brake_pulse));

// File: atctb_pins.sv
/* Far-side pins: channels, external trigger, master timer trigger.
   Assumes the bench starts a burst only while busy is low. */
`timescale 1ns/10ps
module atctb_pins (
  input wire hclk,
  input wire hresetn,
  input wire go,
  input wire [1:0] pin_sel,
  input wire [7:0] rises,
  output reg [3:0] channel_in,
  output reg external_trigger_input,
  output reg [1:0] internal_trigger,
  output wire busy
);
  reg [8:0] left_ff;
  reg ph_ff;
  assign busy = go || left_ff != 9'h000;
  // Two cycles per level so a short filter still passes; level held after
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_ff <= 9'h000;
      ph_ff <= 1'b0;
      channel_in <= 4'h0;
      external_trigger_input <= 1'b0;
      internal_trigger <= 2'h0;
    end else if (go) begin
      left_ff <= {rises, 1'b0};
    end else if (left_ff != 9'h000) begin
      ph_ff <= ~ph_ff;
      if (ph_ff) begin
        left_ff <= left_ff - 9'h001;
        case (pin_sel)
          2'h0: channel_in[0] <= ~channel_in[0];
          2'h1: channel_in[1] <= ~channel_in[1];
          2'h2: external_trigger_input <= ~external_trigger_input;
          default: internal_trigger[1] <= ~internal_trigger[1];
        endcase
      end
    end
  end
endmodule

// File: atctb_core_tb.sv
/* Self-checking bench for atctb_core over AHB-Lite.
   Assumes the pin model on the far side and the bound checker. */
`timescale 1ns/10ps
`include "atctb_regs.vh"
module atctb_core_tb;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [11:0] haddr = 12'h000;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [3:0] capture_event = 4'h0;
  reg brake_event = 1'b0;
  reg go = 1'b0;
  reg [1:0] pin_sel = 2'h0;
  reg [7:0] rises = 8'h00;
  wire [31:0] hrdata;
  wire hreadyout, hresp, external_trigger_input, busy, pwm_input_channel;
  wire ch1_both_edge_pulse, update_event, trigger_event, brake_pulse;
  wire [3:0] channel_in, channel_filtered, cc_event;
  wire [1:0] internal_trigger;
  wire [15:0] count_value;
  integer failures = 0;
  integer check_count = 0;
  integer upd_n, edge_n, trg_n, pwm_n, k;
  reg [31:0] rd;
  atctb_core i_atctb_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .channel_in(channel_in),
    .external_trigger_input(external_trigger_input), .internal_trigger(internal_trigger),
    .capture_event(capture_event), .brake_event(brake_event),
    .channel_filtered(channel_filtered), .pwm_input_channel(pwm_input_channel),
    .ch1_both_edge_pulse(ch1_both_edge_pulse), .count_value(count_value),
    .update_event(update_event), .trigger_event(trigger_event), .cc_event(cc_event),
    .brake_pulse(brake_pulse));
  atctb_pins i_atctb_pins (.hclk(hclk), .hresetn(hresetn), .go(go), .pin_sel(pin_sel),
    .rises(rises), .channel_in(channel_in), .external_trigger_input(external_trigger_input),
    .internal_trigger(internal_trigger), .busy(busy));
  initial begin
    forever #5 hclk = ~hclk;
  end
  task tally_and_finish;
    begin
      if (failures == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One single transfer; waits on hready at both phases
  task xfer(input wr_en, input [11:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr_en;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      hwdata <= ~d;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  // Sample just after the edge, once its updates have landed
  task step;
    begin
      @(posedge hclk);
      #1;
    end
  endtask
  task seq(input [79:0] e, input integer n, input integer gap);
    integer i, c;
    reg [15:0] last;
    begin
      #1;
      for (i = 0; i < n; i = i + 1) begin
        last = count_value;
        c = 0;
        while (count_value === last) begin
          step;
          c = c + 1;
        end
        chk(count_value, e[79-16*i -: 16]);
        if (i > 0) chk(c, gap);
      end
    end
  endtask
  task upd_gap(input integer e);
    integer c;
    begin
      #1;
      while (update_event !== 1'b1) step;
      c = 0;
      step;
      c = 1;
      while (update_event !== 1'b1) begin
        step;
        c = c + 1;
      end
      chk(c, e);
    end
  endtask
  task watch(input integer n);
    begin
      upd_n = 0;
      edge_n = 0;
      trg_n = 0;
      pwm_n = 0;
      repeat (n) begin
        step;
        if (update_event === 1'b1) upd_n = upd_n + 1;
        if (ch1_both_edge_pulse === 1'b1) edge_n = edge_n + 1;
        if (trigger_event === 1'b1) trg_n = trg_n + 1;
        if (pwm_input_channel === 1'b1) pwm_n = pwm_n + 1;
      end
    end
  endtask
  task burst(input [1:0] p, input [7:0] n);
    begin
      @(posedge hclk);
      pin_sel <= p;
      rises <= n;
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      @(posedge hclk);
      while (busy === 1'b1) @(posedge hclk);
      repeat (4) @(posedge hclk);
    end
  endtask
  // Whole run is several hundred cycles
  initial begin
    #300000;
    failures = failures + 1;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`ATCTB_CTRL_OFS, 32'h0);
    rdc(`ATCTB_SMC_OFS, 32'h0);
    rdc(`ATCTB_RLD_OFS, 32'h0000FFFF);
    rdc(`ATCTB_DIV_OFS, 32'h0);
    rdc(`ATCTB_STS_OFS, 32'h0);
    wr(12'h100, 32'hFFFFFFFF);
    rdc(12'h100, 32'h0);
    wr(`ATCTB_CNT_OFS, 32'hFFFFFFFF);
    rdc(`ATCTB_CNT_OFS, 32'h0000FFFF);
    wr(`ATCTB_REP_OFS, 32'hFFFFFFFF);
    rdc(`ATCTB_REP_OFS, 32'h000000FF);
    // Up, down and center counting
    wr(`ATCTB_REP_OFS, 32'h0);
    wr(`ATCTB_RLD_OFS, 32'h3);
    wr(`ATCTB_DIV_OFS, 32'h1);
    wr(`ATCTB_EGR_OFS, 32'h1);
    wr(`ATCTB_CNT_OFS, 32'h0);
    wr(`ATCTB_CTRL_OFS, 32'h1);
    seq({16'h1, 16'h2, 16'h3, 16'h0, 16'h1}, 5, 2);
    wr(`ATCTB_CTRL_OFS, 32'h0);
    wr(`ATCTB_DIV_OFS, 32'h0);
    wr(`ATCTB_EGR_OFS, 32'h1);
    wr(`ATCTB_CNT_OFS, 32'h3);
    wr(`ATCTB_CTRL_OFS, 32'h5);
    seq({16'h2, 16'h1, 16'h0, 16'h3, 16'h2}, 5, 1);
    wr(`ATCTB_CTRL_OFS, 32'h0);
    wr(`ATCTB_CNT_OFS, 32'h0);
    wr(`ATCTB_CTRL_OFS, 32'h9);
    seq({16'h1, 16'h2, 16'h3, 16'h2, 16'h1}, 5, 1);
    // Update every third wrap, then updates disabled
    wr(`ATCTB_CTRL_OFS, 32'h0);
    wr(`ATCTB_RLD_OFS, 32'h1);
    wr(`ATCTB_REP_OFS, 32'h2);
    wr(`ATCTB_EGR_OFS, 32'h1);
    wr(`ATCTB_CTRL_OFS, 32'h1);
    upd_gap(6);
    wr(`ATCTB_CTRL_OFS, 32'h3);
    watch(30);
    chk(upd_n, 32'h0);
    wr(`ATCTB_CTRL_OFS, 32'h0);
    wr(`ATCTB_STS_OFS, 32'h0);
    @(posedge hclk);
    capture_event <= 4'h5;
    brake_event <= 1'b1;
    @(posedge hclk);
    capture_event <= 4'h0;
    brake_event <= 1'b0;
    rdc(`ATCTB_STS_OFS, 32'hC);
    wr(`ATCTB_STS_OFS, 32'h0);
    rdc(`ATCTB_STS_OFS, 32'h0);
    // Channel, both-edge, external and internal trigger clocks
    wr(`ATCTB_RLD_OFS, 32'hFFFF);
    wr(`ATCTB_CNT_OFS, 32'h0);
    wr(`ATCTB_SMC_OFS, 32'h1);
    wr(`ATCTB_CTRL_OFS, 32'h1);
    burst(2'h0, 8'h05);
    rdc(`ATCTB_CNT_OFS, 32'h5);
    chk(channel_filtered[0] ^ channel_in[0], 32'h0);
    wr(`ATCTB_SMC_OFS, 32'h9);
    step;
    chk(channel_filtered[0] ^ channel_in[0], 32'h1);
    // Filter of four samples drops the two-cycle pin levels
    wr(`ATCTB_SMC_OFS, 32'h41);
    wr(`ATCTB_CNT_OFS, 32'h0);
    burst(2'h0, 8'h05);
    rdc(`ATCTB_CNT_OFS, 32'h0);
    wr(`ATCTB_SMC_OFS, 32'h2);
    wr(`ATCTB_CNT_OFS, 32'h0);
    fork
      burst(2'h0, 8'h03);
      watch(30);
    join
    chk(edge_n, 32'h6);
    chk(trg_n, 32'h6);
    rdc(`ATCTB_CNT_OFS, 32'h6);
    wr(`ATCTB_SMC_OFS, 32'h800);
    fork
      burst(2'h1, 8'h02);
      watch(30);
    join
    chk(pwm_n, 32'h4);
    for (k = 0; k < 4; k = k + 1) begin
      wr(`ATCTB_SMC_OFS, 32'h3 | (k << 8));
      wr(`ATCTB_CNT_OFS, 32'h0);
      burst(2'h2, 8'h08);
      rdc(`ATCTB_CNT_OFS, 32'h8 >> k);
    end
    wr(`ATCTB_SMC_OFS, 32'h4F4);
    wr(`ATCTB_CNT_OFS, 32'h0);
    burst(2'h3, 8'h05);
    rdc(`ATCTB_CNT_OFS, 32'h5);
    wr(`ATCTB_SMC_OFS, 32'h4);
    wr(`ATCTB_CNT_OFS, 32'h0);
    burst(2'h3, 8'h05);
    rdc(`ATCTB_CNT_OFS, 32'h0);
    wr(`ATCTB_CTRL_OFS, 32'h0);
    wr(`ATCTB_SMC_OFS, 32'h1404);
    burst(2'h3, 8'h01);
    rdc(`ATCTB_CTRL_OFS, 32'h1);
    tally_and_finish;
  end
endmodule
